// File: common/arch_regs_cfg.svh
/*
  Constants for the architectural register file: register indices,
  status word layout, reset values and the apb map of the block.
  Assumes inclusion by bare name from design and bench files.
*/
// Overview of operation
// - sixteen 32-bit general registers, indices 0-15
// - register zero doubles as index register
// - register fifteen is the hardware stack pointer
// - global base added to peripheral displacements
// - vector base locates the exception table
// - status bits 31-10, 3, 2 read zero
// - status bits 9,8 are divide-step flags
// - status bits 7-4 mask level, reset ones
// - status bit 1 is saturation control
// - status bit 0 holds compare outcome
// - bit 0 also takes carry and overflow
// - mac high and low take multiply results
// - return register holds subroutine return address
// - program counter reads as current plus four to the pipeline, raw over apb
// - reset loads stack pointer, pc; clears vector base
// - byte and word loads are sign-extended
// - misaligned word or long access is error
// - stack entries are aligned 32-bit words only
// - immediate sign-extended for move, add, cmpeq
// - immediate zero-extended for test, and, or, xor
// - wide immediates fetched pc-relative from memory
`ifndef ARCH_REGS_CFG_SVH
`define ARCH_REGS_CFG_SVH

`define GPR_INDEX 4'h0
`define GPR_SP 4'hf

// status word fields
`define PSW_COND 0
`define PSW_SAT 1
`define PSW_MASK_LO 4
`define PSW_MASK_HI 7
`define PSW_DIV_Q 8
`define PSW_DIV_M 9
`define PSW_WMASK 32'h0000_03f3
`define PSW_MASK_RESET 4'hf
`define VBR_RESET 32'h0000_0000
`define PC_AHEAD 32'h0000_0004
`define STACK_ALIGN_MASK 32'h0000_0003
`define PC_LONG_MASK 32'hffff_fffc

// apb map: 0x000-0x03c general, then status, then control/system, then alignment flag
`define APB_GPR_BASE 12'h000
`define APB_GPR_PAGE 6'h00
`define APB_PSW 12'h040
`define APB_GBR 12'h044
`define APB_VBR 12'h048
`define APB_MAC_RESULT_HIGH 12'h04c
`define APB_MAC_RESULT_LOW 12'h050
`define APB_PR 12'h054
`define APB_PC 12'h058
`define APB_ALIGN 12'h05c

`endif

// File: common/arch_regs_pkg.sv
/*
  Types for the architectural register file.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package arch_regs_pkg;
  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } access_size_t;

  typedef enum logic [1:0] {
    imm_sign = 2'h0,
    imm_zero = 2'h1
  } imm_kind_t;
endpackage : arch_regs_pkg

// File: rtl/arch_regs.sv
/*
  Architectural register file of the core: sixteen general registers,
  status word, global and vector base, mac pair, return register and pc,
  plus operand extension and alignment checks for the pipeline.
  Assumes the pipeline drives its ports on pclk; software and debug
  reach every register over an apb slave with zero wait states.
*/
`include "arch_regs_cfg.svh"

module arch_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset vectors fetched from the exception table
  input wire logic vec_load,
  input wire logic [31:0] vec_sp,
  input wire logic [31:0] vec_pc,
  // general register ports
  input wire logic [3:0] rd_a_sel,
  input wire logic [3:0] rd_b_sel,
  input wire logic gpr_we,
  input wire logic [3:0] gpr_wsel,
  input wire logic [31:0] gpr_wdata,
  // load data path into the general registers
  input wire logic load_we,
  input wire logic [3:0] load_sel,
  input wire logic [31:0] load_data,
  input wire arch_regs_pkg::access_size_t load_size,
  // immediate operand
  input wire logic [7:0] imm8,
  input wire arch_regs_pkg::imm_kind_t imm_kind,
  // memory access alignment check
  input wire logic mem_req,
  input wire logic mem_stack,
  input wire logic [31:0] mem_addr,
  input wire arch_regs_pkg::access_size_t mem_size,
  // status word updates
  input wire logic cond_we,
  input wire logic cond_in,
  input wire logic divq_we,
  input wire logic divq_m,
  input wire logic divq_q,
  input wire logic psw_we,
  input wire logic [31:0] psw_wdata,
  // control and system register writes
  input wire logic gbr_we,
  input wire logic vbr_we,
  input wire logic mac_we,
  input wire logic [31:0] mac_result_high_wdata,
  input wire logic [31:0] mac_result_low_wdata,
  input wire logic pr_we,
  input wire logic [31:0] pr_wdata,
  input wire logic pc_we,
  input wire logic [31:0] pc_wdata,
  // registered operand outputs
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  output logic [31:0] index_data,
  output logic [31:0] sp_data,
  output logic [31:0] imm_data,
  output logic [31:0] pc_read,
  output logic [31:0] pc_lit_base,
  output logic [31:0] gbr_data,
  output logic [31:0] vbr_data,
  output logic [31:0] psw_data,
  output logic [31:0] mac_result_high_data,
  output logic [31:0] mac_result_low_data,
  output logic [31:0] pr_data,
  output logic addr_error
);

  logic [31:0] gpr_reg [0:15];
  logic [31:0] gpr_next [0:15];
  logic [9:0] psw_reg;
  logic [9:0] psw_next;
  logic [31:0] gbr_reg;
  logic [31:0] vbr_reg;
  logic [31:0] mac_result_high_reg;
  logic [31:0] mac_result_low_reg;
  logic [31:0] pr_reg;
  logic [31:0] pc_reg;
  logic align_err_reg;

  // apb decode
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd_setup = psel & ~penable & ~pwrite;
  wire hit_gpr = paddr[11:6] == `APB_GPR_PAGE;
  wire [3:0] apb_gidx = paddr[5:2];
  wire hit_psw = paddr == `APB_PSW;
  wire hit_gbr = paddr == `APB_GBR;
  wire hit_vbr = paddr == `APB_VBR;
  wire hit_mac_result_high = paddr == `APB_MAC_RESULT_HIGH;
  wire hit_mac_result_low = paddr == `APB_MAC_RESULT_LOW;
  wire hit_pr = paddr == `APB_PR;
  wire hit_pc = paddr == `APB_PC;
  wire hit_align = paddr == `APB_ALIGN;
  wire hit_any = hit_gpr | hit_psw | hit_gbr | hit_vbr | hit_mac_result_high
    | hit_mac_result_low | hit_pr | hit_pc | hit_align;
  wire misaligned_apb = paddr[1:0] != 2'h0;
  wire apb_ok = hit_any & ~misaligned_apb;

  // write strobes per register, taken in the access phase only
  wire wr_ok = apb_wr & ~misaligned_apb;
  wire wr_psw = wr_ok & hit_psw;
  wire wr_gbr = wr_ok & hit_gbr;
  wire wr_vbr = wr_ok & hit_vbr;
  wire wr_mac_result_high = wr_ok & hit_mac_result_high;
  wire wr_mac_result_low = wr_ok & hit_mac_result_low;
  wire wr_pr = wr_ok & hit_pr;
  wire wr_pc = wr_ok & hit_pc;
  wire wr_align_clr = wr_ok & hit_align & pwdata[0];

  // only the writable status bits survive a whole-word write
  wire [31:0] psw_bus_masked = pwdata & `PSW_WMASK;
  wire [31:0] psw_pipe_masked = psw_wdata & `PSW_WMASK;

  // reserved status bits never stored, so they read zero
  wire [31:0] psw_full = {22'h000000, psw_reg[9:4], 2'h0, psw_reg[1:0]};

  // pc is read two instructions ahead of the executing one
  wire [31:0] pc_ahead = pc_reg + `PC_AHEAD;

  wire [31:0] rd_mux = hit_gpr ? gpr_reg[apb_gidx] :
    hit_psw ? psw_full :
    hit_gbr ? gbr_reg :
    hit_vbr ? vbr_reg :
    hit_mac_result_high ? mac_result_high_reg :
    hit_mac_result_low ? mac_result_low_reg :
    hit_pr ? pr_reg :
    hit_pc ? pc_reg :
    hit_align ? {31'h00000000, align_err_reg} : 32'h0000_0000;

  // load extension: byte and word sign-extended to full width
  wire [31:0] load_ext =
    (load_size == arch_regs_pkg::size_byte) ?
      {{24{load_data[7]}}, load_data[7:0]} :
    (load_size == arch_regs_pkg::size_word) ?
      {{16{load_data[15]}}, load_data[15:0]} : load_data;

  // arithmetic immediates sign-extend, logical ones zero-extend
  wire [31:0] imm_ext = (imm_kind == arch_regs_pkg::imm_sign) ?
    {{24{imm8[7]}}, imm8} :
    {24'h000000, imm8};

  // alignment: non-stack bytes anywhere, words on 2n, longs on 4n, stack longs only on 4n
  wire word_bad = (mem_size == arch_regs_pkg::size_word) & mem_addr[0];
  wire long_bad = (mem_size == arch_regs_pkg::size_long) &
    ((mem_addr & `STACK_ALIGN_MASK) != 32'h0000_0000);
  wire stack_bad = mem_stack &
    ((mem_size != arch_regs_pkg::size_long) |
     ((mem_addr & `STACK_ALIGN_MASK) != 32'h0000_0000));
  wire mem_bad = mem_req & (word_bad | long_bad | stack_bad);

  // wide immediates come from a pc-relative table; longword base masked
  wire [31:0] lit_base = pc_ahead & `PC_LONG_MASK;

  // general register next values; pipeline write wins over apb write
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      gpr_next[i] = gpr_reg[i];
      if (apb_wr & hit_gpr & ~misaligned_apb & (apb_gidx == 4'(i))) begin
        gpr_next[i] = pwdata;
      end
      if (load_we & (load_sel == 4'(i))) begin
        gpr_next[i] = load_ext;
      end
      if (gpr_we & (gpr_wsel == 4'(i))) begin
        gpr_next[i] = gpr_wdata;
      end
    end
    // stack pointer taken from the vector table on reset fetch
    if (vec_load) begin
      gpr_next[`GPR_SP] = vec_sp;
    end
  end

  // status word: whole writes masked, then bit and mask-field hardware updates
  always_comb begin
    psw_next = psw_reg;
    if (wr_psw) begin
      psw_next = psw_bus_masked[9:0];
    end
    if (psw_we) begin
      psw_next = psw_pipe_masked[9:0];
    end
    if (divq_we) begin
      psw_next[`PSW_DIV_M] = divq_m;
      psw_next[`PSW_DIV_Q] = divq_q;
    end
    // compare result, carry, borrow and overflow all land here
    if (cond_we) begin
      psw_next[`PSW_COND] = cond_in;
    end
    if (vec_load) begin
      psw_next[`PSW_MASK_HI:`PSW_MASK_LO] = `PSW_MASK_RESET;
    end
  end

  // general registers have no reset value; the other registers take reset values
  always_ff @(posedge pclk) begin
    gpr_reg <= gpr_next;
  end

  // status word: mask level reset to all ones, the rest cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_reg <= {2'h0, `PSW_MASK_RESET, 4'h0};
    end else begin
      psw_reg <= psw_next;
    end
  end

  // pipeline write beats a bus write landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gbr_reg <= 32'h0000_0000;
    end else if (gbr_we) begin
      gbr_reg <= gpr_wdata;
    end else if (wr_gbr) begin
      gbr_reg <= pwdata;
    end
  end

  // vector fetch clears the table base before anything else lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbr_reg <= `VBR_RESET;
    end else if (vec_load) begin
      vbr_reg <= `VBR_RESET;
    end else if (vbr_we) begin
      vbr_reg <= gpr_wdata;
    end else if (wr_vbr) begin
      vbr_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_result_high_reg <= 32'h0000_0000;
    end else if (mac_we) begin
      mac_result_high_reg <= mac_result_high_wdata;
    end else if (wr_mac_result_high) begin
      mac_result_high_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_result_low_reg <= 32'h0000_0000;
    end else if (mac_we) begin
      mac_result_low_reg <= mac_result_low_wdata;
    end else if (wr_mac_result_low) begin
      mac_result_low_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr_reg <= 32'h0000_0000;
    end else if (pr_we) begin
      pr_reg <= pr_wdata;
    end else if (wr_pr) begin
      pr_reg <= pwdata;
    end
  end

  // pc holds the raw address; the ahead offset is added on the pipeline read, not the apb read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= 32'h0000_0000;
    end else if (vec_load) begin
      pc_reg <= vec_pc;
    end else if (pc_we) begin
      pc_reg <= pc_wdata;
    end else if (wr_pc) begin
      pc_reg <= pwdata;
    end
  end

  // sticky error: a new fault wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_err_reg <= 1'b0;
    end else if (mem_bad) begin
      align_err_reg <= 1'b1;
    end else if (wr_align_clr) begin
      align_err_reg <= 1'b0;
    end
  end

  // unmapped or misaligned reads answer zero
  wire [31:0] rd_value = apb_ok ? rd_mux : 32'h0000_0000;

  // ready in the access phase only; one setup cycle per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~apb_ok;
    end
  end

  // latched in the setup cycle, holds until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd_setup) begin
      prdata <= rd_value;
    end
  end

  // general register views for the pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_a_data <= 32'h0000_0000;
      rd_b_data <= 32'h0000_0000;
      index_data <= 32'h0000_0000;
      sp_data <= 32'h0000_0000;
    end else begin
      rd_a_data <= gpr_reg[rd_a_sel];
      rd_b_data <= gpr_reg[rd_b_sel];
      index_data <= gpr_reg[`GPR_INDEX];
      sp_data <= gpr_reg[`GPR_SP];
    end
  end

  // operand views: immediate and pc-derived values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imm_data <= 32'h0000_0000;
      pc_read <= 32'h0000_0000;
      pc_lit_base <= 32'h0000_0000;
    end else begin
      imm_data <= imm_ext;
      pc_read <= pc_ahead;
      pc_lit_base <= lit_base;
    end
  end

  // control and system register views
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gbr_data <= 32'h0000_0000;
      vbr_data <= `VBR_RESET;
      psw_data <= 32'h0000_0000;
      mac_result_high_data <= 32'h0000_0000;
      mac_result_low_data <= 32'h0000_0000;
      pr_data <= 32'h0000_0000;
    end else begin
      gbr_data <= gbr_reg;
      vbr_data <= vbr_reg;
      psw_data <= psw_full;
      mac_result_high_data <= mac_result_high_reg;
      mac_result_low_data <= mac_result_low_reg;
      pr_data <= pr_reg;
    end
  end

  // high one cycle after each bad request cycle, for as long as the request lasts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_error <= 1'b0;
    end else begin
      addr_error <= mem_bad;
    end
  end

endmodule : arch_regs

// File: bench/arch_regs_assertions.sv
/*
  Checker for the register file, bound to the ports of arch_regs.
  Assumes one clock pclk and the active-low asynchronous presetn.
*/
module arch_regs_assertions (
  // clock, reset and bus handshake
  input logic pclk, presetn, psel, penable, pready,
  // operand and status paths
  input logic [7:0] imm8,
  input arch_regs_pkg::imm_kind_t imm_kind,
  input logic [31:0] imm_data, sp_data, vbr_data, pc_read, psw_data,
  input logic mem_req, mem_stack, addr_error, vec_load, pc_we, psw_we,
  input arch_regs_pkg::access_size_t mem_size,
  input logic [31:0] mem_addr, vec_sp, pc_wdata, psw_wdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PSW_RESERVED:
    assert property ((psw_data & 32'hffff_fc0c) == 32'h0)
    else $error("reserved status bits not zero");
  AST_IMM_SIGN:
    assert property (presetn && imm_kind == arch_regs_pkg::imm_sign |=>
      imm_data == {{24{$past(imm8[7])}}, $past(imm8)})
    else $error("immediate not sign extended");
  AST_IMM_ZERO:
    assert property (presetn && imm_kind == arch_regs_pkg::imm_zero |=>
      imm_data == {24'h0, $past(imm8)})
    else $error("immediate not zero extended");
  AST_LONG_MISALIGN:
    assert property (mem_req && mem_size == arch_regs_pkg::size_long &&
      mem_addr[1:0] != 2'h0 |=> addr_error)
    else $error("misaligned long access not flagged");
  AST_BYTE_FREE:
    assert property (mem_req && !mem_stack &&
      mem_size == arch_regs_pkg::size_byte |=> !addr_error)
    else $error("byte access flagged");
  AST_VEC_LOAD:
    assert property (vec_load |=> ##1
      sp_data == $past(vec_sp, 2) && vbr_data == 32'h0)
    else $error("vector load did not set sp or clear vbr");
  AST_PC_AHEAD:
    assert property (pc_we |=> ##1 pc_read == $past(pc_wdata, 2) + 32'h4)
    else $error("pc read not four ahead");
  AST_MASK_WRITE:
    assert property (psw_we |=> ##1
      psw_data[7:4] == $past(psw_wdata[7:4], 2))
    else $error("mask field not written");
  AST_APB_READY:
    assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
endmodule : arch_regs_assertions

// File: bench/arch_regs_bench.sv
/*
  Bench for the register file: apb tasks and pipeline pokes with
  expected values. Assumes the design and package compile first.
*/
`include "arch_regs_cfg.svh"

module arch_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, vec_load = 1'b0, gpr_we = 1'b0, load_we = 1'b0;
  logic mem_req = 1'b0, mem_stack = 1'b0, cond_we = 1'b0, cond_in = 1'b0;
  logic divq_we = 1'b0, divq_m = 1'b0, divq_q = 1'b0, psw_we = 1'b0;
  logic gbr_we = 1'b0, vbr_we = 1'b0, mac_we = 1'b0, pr_we = 1'b0;
  logic pc_we = 1'b0, pready, pslverr, addr_error;
  logic [3:0] rd_a_sel = 4'h0, rd_b_sel = 4'h0, gpr_wsel = 4'h0;
  logic [3:0] load_sel = 4'h3;
  logic [7:0] imm8 = 8'h80;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, vec_sp = 32'h7ff0, vec_pc = 32'h102;
  logic [31:0] gpr_wdata = 32'h0, load_data = 32'h0, mem_addr = 32'h0;
  logic [31:0] psw_wdata = 32'h0, mac_result_high_wdata = 32'h0, mac_result_low_wdata = 32'h0;
  logic [31:0] pr_wdata = 32'h0, pc_wdata = 32'h0, prdata, rd_a_data;
  logic [31:0] rd_b_data, index_data, sp_data, imm_data, pc_read;
  logic [31:0] pc_lit_base, gbr_data, vbr_data, psw_data, mac_result_high_data;
  logic [31:0] mac_result_low_data, pr_data;
  arch_regs_pkg::access_size_t load_size = arch_regs_pkg::size_byte;
  arch_regs_pkg::access_size_t mem_size = arch_regs_pkg::size_byte;
  arch_regs_pkg::imm_kind_t imm_kind = arch_regs_pkg::imm_sign;
  int bad_count = 0, total_checks = 0;
  // load cases: data, expected, size
  logic [31:0] ld_d[4] = '{32'h80, 32'h1234_567f, 32'h8001, 32'h8000_0000};
  logic [31:0] ld_x[4] = '{32'hffff_ff80, 32'h7f, 32'hffff_8001,
    32'h8000_0000};
  logic [1:0] ld_s[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  // alignment cases: address, size, stack flag, error
  logic [31:0] al_a[7] = '{32'h1003, 32'h1001, 32'h1002, 32'h1002,
    32'h1004, 32'h1004, 32'h1008};
  logic [1:0] al_s[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
  logic [6:0] al_k = 7'h60, al_e = 7'h2a;
  logic [31:0] q;

  arch_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .vec_load, .vec_sp, .vec_pc,
    .rd_a_sel, .rd_b_sel, .gpr_we, .gpr_wsel, .gpr_wdata, .load_we,
    .load_sel, .load_data, .load_size, .imm8, .imm_kind, .mem_req,
    .mem_stack, .mem_addr, .mem_size, .cond_we, .cond_in, .divq_we,
    .divq_m, .divq_q, .psw_we, .psw_wdata, .gbr_we, .vbr_we, .mac_we,
    .mac_result_high_wdata, .mac_result_low_wdata, .pr_we, .pr_wdata, .pc_we, .pc_wdata,
    .rd_a_data, .rd_b_data, .index_data, .sp_data, .imm_data, .pc_read,
    .pc_lit_base, .gbr_data, .vbr_data, .psw_data, .mac_result_high_data,
    .mac_result_low_data, .pr_data, .addr_error);

  always #5 pclk = ~pclk;

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; read data and error compared at the ready edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    if (!wr) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // pipeline inputs are taken at the next edge, shown one edge later
  task settle2;
    @(posedge pclk);
    @(posedge pclk);
    #1;
  endtask : settle2

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    gpr_wdata <= 32'h1234_5670;
    {gbr_we, vbr_we, vec_load} <= 3'h6;
    @(posedge pclk);
    {gbr_we, vbr_we, vec_load} <= 3'h1;
    settle2();
    chk(gbr_data, 32'h1234_5670);
    chk(sp_data, 32'h7ff0);
    chk(vbr_data, 32'h0);
    chk(psw_data & 32'hf0, 32'hf0);
    chk(pc_read, 32'h106);
    chk(pc_lit_base, 32'h104);
    chk(imm_data, 32'hffff_ff80);
    apb(1'b0, `APB_PC, 32'h0, 32'h102, 1'b0);
    @(posedge pclk);
    vec_load <= 1'b0;
    $display("test reset vectors done");
    apb(1'b1, `APB_PSW, 32'hffff_fc0c, 32'h0, 1'b0);
    apb(1'b0, `APB_PSW, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `APB_PSW, 32'hffff_ffff, 32'h0, 1'b0);
    apb(1'b0, `APB_PSW, 32'h0, 32'h3f3, 1'b0);
    psw_we <= 1'b1;
    psw_wdata <= 32'h350;
    @(posedge pclk);
    psw_we <= 1'b0;
    {cond_we, cond_in, divq_we, divq_m} <= 4'hf;
    settle2();
    chk(psw_data, 32'h251);
    @(posedge pclk);
    {cond_we, divq_we} <= 2'h0;
    $display("test status word done");
    for (int i = 0; i < 16; i++)
      apb(1'b1, 12'(i * 4), {8'h5a, 24'(i)}, 32'h0, 1'b0);
    for (int i = 0; i < 16; i++)
      apb(1'b0, 12'(i * 4), 32'h0, {8'h5a, 24'(i)}, 1'b0);
    chk(index_data, 32'h5a00_0000);
    chk(sp_data, 32'h5a00_000f);
    {gpr_we, gpr_wsel, rd_a_sel, rd_b_sel} <= {1'b1, 12'h770};
    gpr_wdata <= 32'hdead_beef;
    @(posedge pclk);
    gpr_we <= 1'b0;
    @(posedge pclk);
    #1;
    chk(rd_a_data, 32'hdead_beef);
    chk(rd_b_data, 32'h5a00_0000);
    apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h042, 32'h0, 32'h0, 1'b1);
    $display("test general registers done");
    @(posedge pclk);
    rd_a_sel <= 4'h3;
    for (int i = 0; i < 4; i++) begin
      load_we <= 1'b1;
      load_data <= ld_d[i];
      load_size <= arch_regs_pkg::access_size_t'(ld_s[i]);
      @(posedge pclk);
      load_we <= 1'b0;
      settle2();
      chk(rd_a_data, ld_x[i]);
      @(posedge pclk);
    end
    imm_kind <= arch_regs_pkg::imm_zero;
    @(posedge pclk);
    #1;
    chk(imm_data, 32'h80);
    for (int i = 0; i < 7; i++) begin
      @(posedge pclk);
      {mem_req, mem_stack, mem_addr} <= {1'b1, al_k[i], al_a[i]};
      mem_size <= arch_regs_pkg::access_size_t'(al_s[i]);
      @(posedge pclk);
      mem_req <= 1'b0;
      #1;
      chk({31'h0, addr_error}, {31'h0, al_e[i]});
    end
    apb(1'b0, `APB_ALIGN, 32'h0, 32'h1, 1'b0);
    apb(1'b1, `APB_ALIGN, 32'h1, 32'h0, 1'b0);
    apb(1'b0, `APB_ALIGN, 32'h0, 32'h0, 1'b0);
    $display("test extension and alignment done");
    {mac_we, pr_we, pc_we, vbr_we} <= 4'hf;
    {mac_result_high_wdata, mac_result_low_wdata} <= {32'h1111_2222, 32'h3333_4444};
    {pr_wdata, pc_wdata} <= {32'ha00, 32'h2000};
    @(posedge pclk);
    {mac_we, pr_we, pc_we, vbr_we} <= 4'h0;
    apb(1'b0, `APB_MAC_RESULT_HIGH, 32'h0, 32'h1111_2222, 1'b0);
    apb(1'b0, `APB_MAC_RESULT_LOW, 32'h0, 32'h3333_4444, 1'b0);
    apb(1'b0, `APB_PR, 32'h0, 32'ha00, 1'b0);
    chk(pc_read, 32'h2004);
    chk(mac_result_high_data, 32'h1111_2222);
    chk(mac_result_low_data, 32'h3333_4444);
    chk(pr_data, 32'ha00);
    chk(vbr_data, 32'hdead_beef);
    $display("test system registers done");
    report_and_stop();
  end
endmodule : arch_regs_bench

bind arch_regs arch_regs_assertions chk_i (.pclk, .presetn, .psel,
  .penable, .pready, .imm8, .imm_kind, .imm_data, .sp_data, .vbr_data,
  .pc_read, .psw_data, .mem_req, .mem_stack, .addr_error, .vec_load,
  .pc_we, .psw_we, .mem_size, .mem_addr, .vec_sp, .pc_wdata, .psw_wdata);
